// ==== src/cdbu_top.sv ====
// Debug breakpoint unit: saved state, scratch, breakpoints and watchpoints
`timescale 1ns/1ps
`default_nettype none
module cdbu_top
    import cdbu_pkg::*;
#(
    parameter int NTHR = 8
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pipe_valid,
    input  wire logic [7:0]  pipe_thread,
    input  wire logic [31:0] pipe_pc,
    input  wire logic        mem_valid,
    input  wire logic        mem_load,
    input  wire logic [7:0]  mem_thread,
    input  wire logic [31:0] mem_addr,
    input  wire logic        res_valid,
    input  wire logic [7:0]  res_thread,
    input  wire logic [31:0] res_id,
    input  wire logic        host_req,
    input  wire logic        debug_call_instr_req,
    input  wire logic [7:0]  debug_call_instr_thread,
    input  wire logic [31:0] saved_stack_pointer,
    input  wire logic        debug_return,
    input  wire logic        cfg_scr_we,
    input  wire logic [2:0]  cfg_scr_idx,
    input  wire logic [31:0] cfg_scr_wdata,
    output logic      [31:0] cfg_scr_rdata,
    output logic             debug_mode,
    output logic             debug_entry,
    output logic      [7:0]  thread_run_en,
    output logic      [7:0]  fetch_thread,
    output logic      [4:0]  fetch_reg
);
    // ************************************************************
    // Register state
    // ************************************************************
    logic [31:0] ssp_ff;
    logic [7:0]  fthr_ff;
    logic [4:0]  freg_ff;
    logic [2:0]  cause_ff;
    logic [1:0]  cidx_ff;
    logic [7:0]  cthr_ff;
    logic [31:0] data_ff;
    logic [7:0]  stop_ff;
    logic        dbg_ff;
    logic [31:0] scr_ff [8];
    logic [31:0] iba_ff [4];
    logic [31:0] ibc_ff [4];
    logic [31:0] dwa1_ff [4];
    logic [31:0] dwa2_ff [4];
    logic [31:0] dwc_ff [4];
    logic [31:0] rwm_ff [4];
    logic [31:0] rwv_ff [4];
    logic [31:0] rwc_ff [4];

    // ************************************************************
    // APB decode
    // ************************************************************
    wire        wr_acc = psel & penable & pwrite & clk_en;
    wire [7:0]  idx    = paddr[9:2];
    wire [7:0]  sub    = idx - IDX_SCRATCH;
    wire [1:0]  bi     = idx[1:0];
    wire        hit_scr = (idx[7:3] == IDX_SCRATCH[7:3]);
    wire        hit_iba = (idx[7:2] == IDX_IB_ADDR[7:2]);
    wire        hit_ibc = (idx[7:2] == IDX_IB_CTRL[7:2]);
    wire        hit_dw1 = (idx[7:2] == IDX_DW_ADDR1[7:2]);
    wire        hit_dw2 = (idx[7:2] == IDX_DW_ADDR2[7:2]);
    wire        hit_dwc = (idx[7:2] == IDX_DW_CTRL[7:2]);
    wire        hit_rwm = (idx[7:2] == IDX_RW_MASK[7:2]);
    wire        hit_rwv = (idx[7:2] == IDX_RW_VALUE[7:2]);
    wire        hit_rwc = (idx[7:2] == IDX_RW_CTRL[7:2]);
    wire        hit_one = (idx == IDX_SSP) | (idx == IDX_FETCH_THR) | (idx == IDX_FETCH_REG)
                        | (idx == IDX_CAUSE) | (idx == IDX_DATA) | (idx == IDX_STOP);
    wire        mapped = (paddr[11:10] == 2'h0) & (hit_one | hit_scr | hit_iba | hit_ibc
                        | hit_dw1 | hit_dw2 | hit_dwc | hit_rwm | hit_rwv | hit_rwc);
    wire        wr_ok  = wr_acc & mapped;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // ************************************************************
    // Match logic
    // ************************************************************
    logic [3:0] ib_hit;
    logic [3:0] dw_hit;
    logic [3:0] rw_hit;
    for (genvar i = 0; i < 4; i++) begin : g_match
        wire ib_eq  = (pipe_pc == iba_ff[i]);
        wire dw_a   = (mem_addr >= dwa1_ff[i]);
        wire dw_b   = (mem_addr <= dwa2_ff[i]);
        wire dw_cnd = dwc_ff[i][CTL_SENSE_BIT] ? (dw_a | dw_b) : (dw_a & dw_b);
        wire dw_kind = ~mem_load | dwc_ff[i][CTL_LOAD_BIT];
        wire rw_a   = ((res_id & rwm_ff[i]) == rwv_ff[i]);
        wire rw_cnd = rwc_ff[i][CTL_SENSE_BIT] ? ~rw_a : rw_a;
        assign ib_hit[i] = pipe_valid & ibc_ff[i][CTL_EN_BIT]
                         & ibc_ff[i][CTL_THR_LSB + pipe_thread[2:0]]
                         & (ibc_ff[i][CTL_SENSE_BIT] ? ~ib_eq : ib_eq);
        assign dw_hit[i] = mem_valid & dwc_ff[i][CTL_EN_BIT] & dw_kind & dw_cnd
                         & dwc_ff[i][CTL_THR_LSB + mem_thread[2:0]];
        assign rw_hit[i] = res_valid & rwc_ff[i][CTL_EN_BIT] & rw_cnd
                         & rwc_ff[i][CTL_THR_LSB + res_thread[2:0]];
    end

    function automatic logic [1:0] low_idx(input logic [3:0] v);
        logic [1:0] r;
        r = 2'h0;
        for (int k = 3; k >= 0; k--) begin
            if (v[k]) begin
                r = 2'(k);
            end
        end
        return r;
    endfunction

    // ************************************************************
    // Debug entry selection
    // ************************************************************
    logic [2:0]  nxt_cause;
    logic [1:0]  nxt_cidx;
    logic [7:0]  nxt_cthr;
    logic [31:0] nxt_data;
    logic        trig;
    always_comb begin
        nxt_cause = cause_ff;
        nxt_cidx  = cidx_ff;
        nxt_cthr  = cthr_ff;
        nxt_data  = data_ff;
        trig      = 1'b1;
        if (host_req) begin
            nxt_cause = CAUSE_HOST;
            nxt_cidx  = 2'h0;
            nxt_cthr  = 8'h00;
        end else if (debug_call_instr_req) begin
            nxt_cause = CAUSE_DEBUG_CALL_INSTR;
            nxt_cidx  = 2'h0;
            nxt_cthr  = debug_call_instr_thread;
        end else if (|ib_hit) begin
            nxt_cause = CAUSE_IBRK;
            nxt_cidx  = low_idx(ib_hit);
            nxt_cthr  = pipe_thread;
        end else if (|dw_hit) begin
            nxt_cause = CAUSE_DWAT;
            nxt_cidx  = low_idx(dw_hit);
            nxt_cthr  = mem_thread;
            nxt_data  = mem_addr;
        end else if (|rw_hit) begin
            nxt_cause = CAUSE_RWAT;
            nxt_cidx  = low_idx(rw_hit);
            nxt_cthr  = res_thread;
            nxt_data  = res_id;
        end else begin
            trig = 1'b0;
        end
    end
    wire enter = clk_en & trig & ~dbg_ff;

    // ************************************************************
    // Single registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ssp_ff   <= 32'h0000_0000;
            fthr_ff  <= 8'h00;
            freg_ff  <= 5'h00;
            cause_ff <= CAUSE_RST;
            cidx_ff  <= 2'h0;
            cthr_ff  <= 8'h00;
            data_ff  <= 32'h0000_0000;
            stop_ff  <= 8'h00;
            dbg_ff   <= 1'b0;
        end else if (enter) begin
            ssp_ff   <= saved_stack_pointer;
            cause_ff <= nxt_cause;
            cidx_ff  <= nxt_cidx;
            cthr_ff  <= nxt_cthr;
            data_ff  <= nxt_data;
            dbg_ff   <= 1'b1;
        end else if (clk_en) begin
            if (debug_return) begin
                dbg_ff <= 1'b0;
            end
            if (wr_ok && idx == IDX_SSP) begin
                ssp_ff <= pwdata;
            end
            if (wr_ok && idx == IDX_FETCH_THR) begin
                fthr_ff <= pwdata[7:0];
            end
            if (wr_ok && idx == IDX_FETCH_REG) begin
                freg_ff <= pwdata[4:0];
            end
            if (wr_ok && idx == IDX_CAUSE) begin
                cause_ff <= pwdata[2:0];
                cthr_ff  <= pwdata[CAUSE_THR_LSB +: 8];
                cidx_ff  <= pwdata[CAUSE_IDX_LSB +: 2];
            end
            if (wr_ok && idx == IDX_DATA) begin
                data_ff <= pwdata;
            end
            if (wr_ok && idx == IDX_STOP) begin
                stop_ff <= pwdata[7:0];
            end
        end
    end

    // ************************************************************
    // Banked registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                scr_ff[i] <= 32'h0000_0000;
            end
            for (int i = 0; i < 4; i++) begin
                iba_ff[i]  <= 32'h0000_0000;
                ibc_ff[i]  <= CTRL_RST;
                dwa1_ff[i] <= 32'h0000_0000;
                dwa2_ff[i] <= 32'h0000_0000;
                dwc_ff[i]  <= CTRL_RST;
                rwm_ff[i]  <= 32'h0000_0000;
                rwv_ff[i]  <= 32'h0000_0000;
                rwc_ff[i]  <= CTRL_RST;
            end
        end else if (clk_en) begin
            if (wr_ok && hit_scr) begin
                scr_ff[sub[2:0]] <= pwdata;
            end else if (cfg_scr_we) begin
                scr_ff[cfg_scr_idx] <= cfg_scr_wdata;
            end
            if (wr_ok && hit_iba) begin
                iba_ff[bi] <= pwdata;
            end
            if (wr_ok && hit_ibc) begin
                ibc_ff[bi] <= pwdata & 32'h00FF_0003;
            end
            if (wr_ok && hit_dw1) begin
                dwa1_ff[bi] <= pwdata;
            end
            if (wr_ok && hit_dw2) begin
                dwa2_ff[bi] <= pwdata;
            end
            if (wr_ok && hit_dwc) begin
                dwc_ff[bi] <= pwdata & 32'h00FF_0007;
            end
            if (wr_ok && hit_rwm) begin
                rwm_ff[bi] <= pwdata;
            end
            if (wr_ok && hit_rwv) begin
                rwv_ff[bi] <= pwdata;
            end
            if (wr_ok && hit_rwc) begin
                rwc_ff[bi] <= pwdata & 32'h00FF_0003;
            end
        end
    end

    // ************************************************************
    // Read mux and outputs
    // ************************************************************
    always_comb begin
        prdata = 32'h0000_0000;
        if (idx == IDX_SSP) prdata = ssp_ff;
        if (idx == IDX_FETCH_THR) prdata = {24'h000000, fthr_ff};
        if (idx == IDX_FETCH_REG) prdata = {27'h0000000, freg_ff};
        if (idx == IDX_CAUSE) prdata = {14'h0000, cidx_ff, cthr_ff, 5'h00, cause_ff};
        if (idx == IDX_DATA) prdata = data_ff;
        if (idx == IDX_STOP) prdata = {24'h000000, stop_ff};
        if (hit_scr) prdata = scr_ff[sub[2:0]];
        if (hit_iba) prdata = iba_ff[bi];
        if (hit_ibc) prdata = ibc_ff[bi];
        if (hit_dw1) prdata = dwa1_ff[bi];
        if (hit_dw2) prdata = dwa2_ff[bi];
        if (hit_dwc) prdata = dwc_ff[bi];
        if (hit_rwm) prdata = rwm_ff[bi];
        if (hit_rwv) prdata = rwv_ff[bi];
        if (hit_rwc) prdata = rwc_ff[bi];
        if (!mapped) prdata = 32'h0000_0000;
    end

    assign cfg_scr_rdata = scr_ff[cfg_scr_idx];
    assign debug_mode    = dbg_ff;
    assign debug_entry   = enter;
    assign thread_run_en = dbg_ff ? 8'h00 : ~stop_ff;
    assign fetch_thread  = fthr_ff;
    assign fetch_reg     = freg_ff;

    // ************************************************************
    // Assertions
    // ************************************************************
    chk_entry_cause: assert property (@(posedge pclk) disable iff (!presetn)
        enter && host_req |=> cause_ff == CAUSE_HOST && cthr_ff == 8'h00 && debug_mode)
        else $error("host entry cause wrong");
    chk_ssp_capture: assert property (@(posedge pclk) disable iff (!presetn)
        enter |=> ssp_ff == $past(saved_stack_pointer))
        else $error("stack pointer not captured");
    chk_stop_mask: assert property (@(posedge pclk) disable iff (!presetn)
        !debug_mode |-> (thread_run_en & stop_ff) == 8'h00)
        else $error("stopped thread allowed to run");
    chk_ib_enable: assert property (@(posedge pclk) disable iff (!presetn)
        |ib_hit |-> ibc_ff[low_idx(ib_hit)][CTL_EN_BIT])
        else $error("disabled breakpoint fired");
    sequence s_dw_entry;
        enter && !host_req && !debug_call_instr_req && ib_hit == 4'h0 && dw_hit != 4'h0;
    endsequence
    chk_dw_data: assert property (@(posedge pclk) disable iff (!presetn)
        s_dw_entry |=> data_ff == $past(mem_addr) && cause_ff == CAUSE_DWAT)
        else $error("watch address not recorded");
    chk_low_index: assert property (@(posedge pclk) disable iff (!presetn)
        enter && !host_req && !debug_call_instr_req && ib_hit[0] |=> cidx_ff == 2'h0)
        else $error("lowest index not chosen");
    chk_rw_data: assert property (@(posedge pclk) disable iff (!presetn)
        enter && nxt_cause == CAUSE_RWAT |=> data_ff == $past(res_id))
        else $error("resource id not recorded");
    chk_fetch_sel: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ok && !enter && idx == IDX_FETCH_REG |=> fetch_reg == $past(pwdata[4:0]))
        else $error("register select not stored");
endmodule
`default_nettype wire

// ==== src/cdbu_pkg.sv ====
// Package of register indices, field positions and codes for the debug breakpoint unit
package cdbu_pkg;
    // Register indices (byte address is four times the index)
    localparam logic [7:0] IDX_SSP        = 8'h12;
    localparam logic [7:0] IDX_FETCH_THR  = 8'h13;
    localparam logic [7:0] IDX_FETCH_REG  = 8'h14;
    localparam logic [7:0] IDX_CAUSE      = 8'h15;
    localparam logic [7:0] IDX_DATA       = 8'h16;
    localparam logic [7:0] IDX_STOP       = 8'h18;
    localparam logic [7:0] IDX_SCRATCH    = 8'h20;
    localparam logic [7:0] IDX_IB_ADDR    = 8'h30;
    localparam logic [7:0] IDX_IB_CTRL    = 8'h40;
    localparam logic [7:0] IDX_DW_ADDR1   = 8'h50;
    localparam logic [7:0] IDX_DW_ADDR2   = 8'h60;
    localparam logic [7:0] IDX_DW_CTRL    = 8'h70;
    localparam logic [7:0] IDX_RW_MASK    = 8'h80;
    localparam logic [7:0] IDX_RW_VALUE   = 8'h90;
    localparam logic [7:0] IDX_RW_CTRL    = 8'h9C;
    // Control field positions
    localparam int CTL_EN_BIT    = 0;
    localparam int CTL_SENSE_BIT = 1;
    localparam int CTL_LOAD_BIT  = 2;
    localparam int CTL_THR_LSB   = 16;
    // Cause register field positions
    localparam int CAUSE_IDX_LSB = 16;
    localparam int CAUSE_THR_LSB = 8;
    // Reset values
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [2:0]  CAUSE_RST = 3'h0;
    // Cause codes
    localparam logic [2:0] CAUSE_HOST  = 3'h1;
    localparam logic [2:0] CAUSE_DEBUG_CALL_INSTR = 3'h2;
    localparam logic [2:0] CAUSE_IBRK  = 3'h3;
    localparam logic [2:0] CAUSE_DWAT  = 3'h4;
    localparam logic [2:0] CAUSE_RWAT  = 3'h5;
endpackage

// ==== verification/cdbu_pipe_model.sv ====
// Pipeline and debug request model driving the far side of the breakpoint unit
`timescale 1ns/1ps
`default_nettype none
module cdbu_pipe_model
    import cdbu_pkg::*;
(
    input  wire logic        pclk,
    output logic             pipe_valid,
    output logic      [7:0]  pipe_thread,
    output logic      [31:0] pipe_pc,
    output logic             mem_valid,
    output logic             mem_load,
    output logic      [7:0]  mem_thread,
    output logic      [31:0] mem_addr,
    output logic             res_valid,
    output logic      [7:0]  res_thread,
    output logic      [31:0] res_id,
    output logic             host_req,
    output logic             debug_call_instr_req,
    output logic      [7:0]  debug_call_instr_thread,
    output logic      [31:0] saved_stack_pointer,
    output logic             debug_return
);
    initial begin
        {pipe_valid, mem_valid, mem_load, res_valid} = '0;
        {host_req, debug_call_instr_req, debug_return} = '0;
        {pipe_thread, mem_thread, res_thread, debug_call_instr_thread} = '0;
        {pipe_pc, mem_addr, res_id, saved_stack_pointer} = '0;
    end

    // ************************************************************
    // One-cycle event, valid and request lines cleared and pc, address and id inverted once released
    // ************************************************************
    task automatic fire(input logic [2:0] k, input logic [7:0] t, input logic [31:0] v,
                        input logic ld);
        @(posedge pclk);
        host_req            <= (k == CAUSE_HOST);
        debug_call_instr_req           <= (k == CAUSE_DEBUG_CALL_INSTR);
        pipe_valid          <= (k == CAUSE_IBRK);
        mem_valid           <= (k == CAUSE_DWAT);
        res_valid           <= (k == CAUSE_RWAT);
        mem_load            <= ld;
        {pipe_thread, mem_thread, res_thread, debug_call_instr_thread} <= {4{t}};
        {pipe_pc, mem_addr, res_id} <= {3{v}};
        saved_stack_pointer <= ~v;
        @(posedge pclk);
        {pipe_valid, mem_valid, res_valid, host_req, debug_call_instr_req} <= '0;
        {pipe_pc, mem_addr, res_id} <= {3{~v}};
    endtask

    // ************************************************************
    // Return from debug mode
    // ************************************************************
    task automatic retn();
        @(posedge pclk);
        debug_return <= 1'b1;
        @(posedge pclk);
        debug_return <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== verification/cdbu_tb_top.sv ====
// Testbench top for the debug breakpoint unit
`timescale 1ns/1ps
`default_nettype none
module cdbu_tb_top
    import cdbu_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
    logic        pipe_valid, mem_valid, mem_load, res_valid, host_req, debug_call_instr_req;
    logic        debug_return, cfg_scr_we, debug_mode, debug_entry, clk_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, pipe_pc, mem_addr, res_id, saved_stack_pointer;
    logic [31:0] cfg_scr_wdata, cfg_scr_rdata, rd_data;
    logic [7:0]  pipe_thread, mem_thread, res_thread, debug_call_instr_thread;
    logic [7:0]  thread_run_en, fetch_thread;
    logic [4:0]  fetch_reg;
    logic [2:0]  cfg_scr_idx;
    logic [7:0]  tix [15];
    logic [31:0] tex [15];
    int          failures, n_checks;
    int          n_entry = 0;

    cdbu_top #(.NTHR(8)) i_cdbu_top (.pclk, .presetn, .clk_en, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pipe_valid, .pipe_thread,
        .pipe_pc, .mem_valid, .mem_load, .mem_thread, .mem_addr, .res_valid, .res_thread,
        .res_id, .host_req, .debug_call_instr_req, .debug_call_instr_thread, .saved_stack_pointer, .debug_return,
        .cfg_scr_we, .cfg_scr_idx, .cfg_scr_wdata, .cfg_scr_rdata, .debug_mode,
        .debug_entry, .thread_run_en, .fetch_thread, .fetch_reg);

    cdbu_pipe_model i_cdbu_pipe_model (.pclk, .pipe_valid, .pipe_thread, .pipe_pc,
        .mem_valid, .mem_load, .mem_thread, .mem_addr, .res_valid, .res_thread, .res_id,
        .host_req, .debug_call_instr_req, .debug_call_instr_thread, .saved_stack_pointer, .debug_return);

    // Count entry pulses seen at the edge that takes them
    always @(posedge pclk) begin
        if (debug_entry === 1'b1) begin
            n_entry <= n_entry + 1;
        end
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            failures++;
            end_of_test();
        end else begin
            rd_data = prdata;
            rd_err  = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, '0);
        chk(rd_data, exp);
    endtask

    task automatic ev(input logic [2:0] k, input logic [7:0] t, input logic [31:0] v,
                      input logic ld, input logic [31:0] cause);
        int e0;
        e0 = n_entry;
        i_cdbu_pipe_model.fire(k, t, v, ld);
        @(posedge pclk);
        chk({31'h0, debug_mode}, {31'h0, cause != 0});
        chk(n_entry - e0, {31'h0, cause != 0});
        if (cause != 0) begin
            rd(IDX_CAUSE, cause);
            if (k > CAUSE_IBRK) begin
                rd(IDX_DATA, v);
            end
            i_cdbu_pipe_model.retn();
        end
    endtask

    // ************************************************************
    // Clock, reset and test sequence
    // ************************************************************
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    initial begin
        {presetn, psel, penable, pwrite, cfg_scr_we} = '0;
        clk_en = 1'b1;
        {paddr, pwdata, cfg_scr_idx, cfg_scr_wdata} = '0;
        {failures, n_checks} = '0;
        tix = '{IDX_SSP, IDX_FETCH_THR, IDX_FETCH_REG, IDX_CAUSE, IDX_DATA, IDX_STOP,
                IDX_SCRATCH + 8'h7, IDX_IB_ADDR + 8'h3, IDX_IB_CTRL + 8'h3,
                IDX_DW_ADDR1 + 8'h3, IDX_DW_ADDR2 + 8'h3, IDX_DW_CTRL + 8'h3,
                IDX_RW_MASK + 8'h3, IDX_RW_VALUE + 8'h3, IDX_RW_CTRL + 8'h3};
        tex = '{32'hFFFF_FFFF, 32'h0000_00FF, 32'h0000_001F, 32'h0003_FF07, 32'hFFFF_FFFF,
                32'h0000_00FF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h00FF_0003, 32'hFFFF_FFFF,
                32'hFFFF_FFFF, 32'h00FF_0007, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h00FF_0003};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        chk({24'h0, thread_run_en}, 32'h0000_00FF);
        rd(IDX_CAUSE, 32'h0000_0000);
        rd(IDX_IB_CTRL, CTRL_RST);
        rd(IDX_DW_CTRL + 8'h2, CTRL_RST);
        rd(IDX_RW_CTRL + 8'h1, CTRL_RST);
        for (int i = 0; i < 15; i++) begin
            wr(tix[i], 32'hFFFF_FFFF);
            rd(tix[i], tex[i]);
        end
        chk({24'h0, fetch_thread}, 32'h0000_00FF);
        chk({27'h0, fetch_reg}, 32'h0000_001F);
        chk({24'h0, thread_run_en}, 32'h0000_0000);
        for (int i = 0; i < 15; i++) begin
            wr(tix[i], 32'h0000_0000);
        end
        wr(8'h17, 32'h1234_5678);
        rd(8'h17, 32'h0000_0000);
        chk({31'h0, rd_err}, 32'h0000_0001);
        clk_en <= 1'b0;
        wr(IDX_DATA, 32'h5A5A_5A5A);
        clk_en <= 1'b1;
        rd(IDX_DATA, 32'h0000_0000);
        $display("test registers done");
        // Scratch shared with config space
        wr(IDX_SCRATCH + 8'h3, 32'hC0DE_0003);
        cfg_scr_idx <= 3'h3;
        @(posedge pclk);
        @(posedge pclk);
        chk(cfg_scr_rdata, 32'hC0DE_0003);
        cfg_scr_we    <= 1'b1;
        cfg_scr_idx   <= 3'h5;
        cfg_scr_wdata <= 32'hBEEF_0005;
        @(posedge pclk);
        cfg_scr_we    <= 1'b0;
        rd(IDX_SCRATCH + 8'h5, 32'hBEEF_0005);
        $display("test scratch done");
        // Host entry, stop mask and debug call instruction entry
        i_cdbu_pipe_model.fire(CAUSE_HOST, 8'h07, 32'h1234_5678, 1'b0);
        @(posedge pclk);
        chk({24'h0, thread_run_en}, 32'h0000_0000);
        rd(IDX_SSP, 32'hEDCB_A987);
        rd(IDX_CAUSE, 32'h0000_0001);
        wr(IDX_STOP, 32'hFFFF_FF05);
        rd(IDX_STOP, 32'h0000_0005);
        i_cdbu_pipe_model.fire(CAUSE_DEBUG_CALL_INSTR, 8'h03, 32'h0000_0000, 1'b0);
        rd(IDX_CAUSE, 32'h0000_0001);
        chk(n_entry, 32'h0000_0001);
        i_cdbu_pipe_model.retn();
        @(posedge pclk);
        chk({24'h0, thread_run_en}, 32'h0000_00FA);
        wr(IDX_STOP, 32'h0000_0000);
        ev(CAUSE_DEBUG_CALL_INSTR, 8'h05, 32'h0000_0000, 1'b0, 32'h0000_0502);
        $display("test entry done");
        // Instruction breakpoints
        wr(IDX_IB_ADDR, 32'h0000_1000);
        wr(IDX_IB_ADDR + 8'h2, 32'h0000_1000);
        wr(IDX_IB_CTRL, 32'h0008_0001);
        wr(IDX_IB_CTRL + 8'h2, 32'h0008_0001);
        ev(CAUSE_IBRK, 8'h04, 32'h0000_1000, 1'b0, 32'h0);
        ev(CAUSE_IBRK, 8'h03, 32'h0000_1000, 1'b0, 32'h0000_0303);
        wr(IDX_IB_CTRL, 32'h0008_0003);
        ev(CAUSE_IBRK, 8'h03, 32'h0000_1000, 1'b0, 32'h0002_0303);
        ev(CAUSE_IBRK, 8'h03, 32'h0000_1004, 1'b0, 32'h0000_0303);
        wr(IDX_IB_CTRL, 32'h0000_0000);
        wr(IDX_IB_CTRL + 8'h2, 32'h0008_0000);
        ev(CAUSE_IBRK, 8'h03, 32'h0000_1000, 1'b0, 32'h0);
        $display("test instruction breakpoints done");
        // Data watchpoints
        wr(IDX_DW_ADDR1 + 8'h1, 32'h0000_0100);
        wr(IDX_DW_ADDR2 + 8'h1, 32'h0000_01FF);
        wr(IDX_DW_CTRL + 8'h1, 32'h0001_0001);
        ev(CAUSE_DWAT, 8'h00, 32'h0000_0180, 1'b0, 32'h0001_0004);
        ev(CAUSE_DWAT, 8'h00, 32'h0000_01FF, 1'b0, 32'h0001_0004);
        ev(CAUSE_DWAT, 8'h00, 32'h0000_0180, 1'b1, 32'h0);
        wr(IDX_DW_CTRL + 8'h1, 32'h0001_0005);
        ev(CAUSE_DWAT, 8'h00, 32'h0000_0100, 1'b1, 32'h0001_0004);
        ev(CAUSE_DWAT, 8'h00, 32'h0000_0300, 1'b0, 32'h0);
        wr(IDX_DW_CTRL + 8'h1, 32'h0001_0003);
        ev(CAUSE_DWAT, 8'h00, 32'h0000_0300, 1'b0, 32'h0001_0004);
        wr(IDX_DW_CTRL + 8'h1, 32'h0000_0000);
        $display("test data watchpoints done");
        // Resource watchpoints
        wr(IDX_RW_MASK + 8'h3, 32'h0000_00FF);
        wr(IDX_RW_VALUE + 8'h3, 32'h0000_0042);
        wr(IDX_RW_CTRL + 8'h3, 32'h0004_0001);
        ev(CAUSE_RWAT, 8'h02, 32'h0000_1242, 1'b0, 32'h0003_0205);
        ev(CAUSE_RWAT, 8'h02, 32'h0000_1243, 1'b0, 32'h0);
        wr(IDX_RW_CTRL + 8'h3, 32'h0004_0003);
        ev(CAUSE_RWAT, 8'h02, 32'h0000_1242, 1'b0, 32'h0);
        ev(CAUSE_RWAT, 8'h02, 32'h0000_1243, 1'b0, 32'h0003_0205);
        $display("test resource watchpoints done");
        end_of_test();
    end
endmodule
`default_nettype wire
